/* File: src/maqc_defines.svh */
// maqc_defines.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the maqc package and design modules
`ifndef MAQC_DEFINES_SVH
`define MAQC_DEFINES_SVH

`define MAQC_CLK_HZ         40000000
`define MAQC_CHAN_GAP_NS    5000
`define MAQC_SCAN_US        200
`define MAQC_CHAN_GAP_CYC   ((`MAQC_CHAN_GAP_NS * 40) / 1000)
`define MAQC_SCAN_CYC       (`MAQC_SCAN_US * 40)
`define MAQC_NCHAN          16
`define MAQC_NDAC           8
`define MAQC_DEPTH          2048
`define MAQC_EIGHTH_LVL     256
`define MAQC_HALF_LVL       1024

// register byte offsets
`define MAQC_OFS_CTRL       12'h000
`define MAQC_OFS_GAP        12'h004
`define MAQC_OFS_STATUS     12'h008
`define MAQC_OFS_FIFO       12'h00C
`define MAQC_OFS_COUNT      12'h010
`define MAQC_OFS_IRQ_STAT   12'h014
`define MAQC_OFS_IRQ_MASK   12'h018
`define MAQC_OFS_DIO_DIR    12'h01C
`define MAQC_OFS_DIO_OUT    12'h020
`define MAQC_OFS_DIO_IN     12'h024
`define MAQC_OFS_DAC0       12'h040

// control fields
`define MAQC_CTRL_RUN       0
`define MAQC_CTRL_EXTCLK    1
`define MAQC_CTRL_OVF_CLR   2

// status and interrupt fields
`define MAQC_ST_EIGHTH      0
`define MAQC_ST_HALF        1
`define MAQC_ST_OVF         2
`define MAQC_ST_EMPTY       3

`define MAQC_DIO_PREAMP     0
`define MAQC_DIO_FOCUS      1

`endif

/* File: src/maqc_pkg.sv */
// maqc_pkg: types for the acquisition board control
// assumes: maqc_defines.svh is on the include path
`include "maqc_defines.svh"
package maqc_pkg;
	typedef enum logic [1:0] {MAQC_IDLE, MAQC_WAIT, MAQC_CONV} maqc_scan_t;
	typedef logic [15:0] maqc_sample_t;
endpackage

/* File: src/maqc_fifo.sv */
// maqc_fifo: 2048 x 16 sample store with fill count
// assumes: single clock; a write when full and a read when empty are ignored
`include "maqc_defines.svh"
module maqc_fifo
	import maqc_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         wr_en,
	input  wire maqc_sample_t wr_data,
	input  wire logic         rd_en,
	output maqc_sample_t      rd_data,
	output logic [11:0]       count
);
	maqc_sample_t mem [0:`MAQC_DEPTH-1];
	logic [10:0]  wr_ptr_reg;
	logic [10:0]  rd_ptr_reg;
	logic [11:0]  count_reg;
	logic         do_wr;
	logic         do_rd;

	assign do_wr   = wr_en && (count_reg != 12'(`MAQC_DEPTH));
	assign do_rd   = rd_en && (count_reg != 12'h000);
	assign rd_data = mem[rd_ptr_reg];
	assign count   = count_reg;

	always_ff @(posedge pclk) begin
		if (do_wr)
			mem[wr_ptr_reg] <= wr_data;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= 11'h000;
			rd_ptr_reg <= 11'h000;
			count_reg  <= 12'h000;
		end else begin
			if (do_wr)
				wr_ptr_reg <= wr_ptr_reg + 11'h001;
			if (do_rd)
				rd_ptr_reg <= rd_ptr_reg + 11'h001;
			count_reg <= count_reg + {11'h000, do_wr} - {11'h000, do_rd};
		end
	end
endmodule // maqc_fifo

/* File: src/maqc_top.sv */
// maqc_top: acquisition and i/o control of a 16 input, 8 output analog board
// assumes: apb master on pclk; converter answers adc_done with adc_data
//
// Chosen here: register access over APB and the placing of the registers.
`include "maqc_defines.svh"
module maqc_top
	import maqc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             scan_clk_out,
	input  wire logic        ext_scan_clk,
	output logic             adc_start,
	output logic [3:0]       adc_chan,
	input  wire logic        adc_done,
	input  wire logic [15:0] adc_data,
	output logic [95:0]      dac_value,
	input  wire logic [3:0]  dio_in,
	output logic [3:0]       dio_out,
	output logic [3:0]       dio_oe,
	output logic             preamp_track,
	output logic             focus_enable
);
	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic        acc;
	logic        wr_acc;
	logic        rd_acc;
	logic        sel_ctrl;
	logic        sel_gap;
	logic        sel_status;
	logic        sel_fifo;
	logic        sel_count;
	logic        sel_istat;
	logic        sel_imask;
	logic        sel_dir;
	logic        sel_dout;
	logic        sel_din;
	logic        sel_dac;
	logic        mapped;

	assign acc        = psel && penable;
	assign wr_acc     = acc && pwrite;
	assign rd_acc     = acc && !pwrite;
	assign sel_ctrl   = paddr == `MAQC_OFS_CTRL;
	assign sel_gap    = paddr == `MAQC_OFS_GAP;
	assign sel_status = paddr == `MAQC_OFS_STATUS;
	assign sel_fifo   = paddr == `MAQC_OFS_FIFO;
	assign sel_count  = paddr == `MAQC_OFS_COUNT;
	assign sel_istat  = paddr == `MAQC_OFS_IRQ_STAT;
	assign sel_imask  = paddr == `MAQC_OFS_IRQ_MASK;
	assign sel_dir    = paddr == `MAQC_OFS_DIO_DIR;
	assign sel_dout   = paddr == `MAQC_OFS_DIO_OUT;
	assign sel_din    = paddr == `MAQC_OFS_DIO_IN;
	assign sel_dac    = (paddr[11:5] == 7'(`MAQC_OFS_DAC0 >> 5)) && (paddr[1:0] == 2'b00);
	assign mapped     = sel_ctrl || sel_gap || sel_status || sel_fifo || sel_count
		|| sel_istat || sel_imask || sel_dir || sel_dout || sel_din || sel_dac;

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	logic        run_reg;
	logic        extclk_reg;
	logic [15:0] gap_reg;
	logic [3:0]  imask_reg;
	logic [3:0]  dir_reg;
	logic [3:0]  dout_reg;
	logic        ovf_clr;

	assign ovf_clr = wr_acc && sel_ctrl && pwdata[`MAQC_CTRL_OVF_CLR];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_reg    <= 1'b0;
			extclk_reg <= 1'b0;
			gap_reg    <= 16'(`MAQC_CHAN_GAP_CYC);
			imask_reg  <= 4'h0;
			dir_reg    <= 4'h0;
			dout_reg   <= 4'h0;
		end else if (wr_acc) begin
			if (sel_ctrl) begin
				run_reg    <= pwdata[`MAQC_CTRL_RUN];
				extclk_reg <= pwdata[`MAQC_CTRL_EXTCLK];
			end
			if (sel_gap)
				gap_reg <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
			if (sel_imask)
				imask_reg <= pwdata[3:0];
			if (sel_dir)
				dir_reg <= pwdata[3:0];
			if (sel_dout)
				dout_reg <= pwdata[3:0];
		end
	end

	// ----------------------------------------------------------------
	// dac holding registers
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `MAQC_NDAC; gi++) begin : g_dac
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					dac_value[gi*12 +: 12] <= 12'h000;
				else if (wr_acc && sel_dac && paddr[4:2] == 3'(gi))
					dac_value[gi*12 +: 12] <= pwdata[11:0];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// scan pacing
	// ----------------------------------------------------------------
	logic [12:0] pace_cnt_reg;
	logic        ext_d_reg;
	logic        tick;
	logic        int_tick;
	logic        ext_tick;

	// pace_cnt runs freely so the output pin stays square while stopped
	assign int_tick = pace_cnt_reg == 13'(`MAQC_SCAN_CYC - 1);
	assign ext_tick = ext_scan_clk && !ext_d_reg;
	assign tick     = run_reg && (extclk_reg ? ext_tick : int_tick);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pace_cnt_reg <= 13'h0000;
			ext_d_reg    <= 1'b0;
			scan_clk_out <= 1'b0;
		end else begin
			pace_cnt_reg <= int_tick ? 13'h0000 : pace_cnt_reg + 13'h0001;
			ext_d_reg    <= ext_scan_clk;
			scan_clk_out <= pace_cnt_reg < 13'(`MAQC_SCAN_CYC / 2);
		end
	end

	// ----------------------------------------------------------------
	// channel sequencer
	// ----------------------------------------------------------------
	maqc_scan_t  state_reg;
	logic [15:0] gap_cnt_reg;
	logic        last_chan;
	logic        push;

	assign last_chan = adc_chan == 4'(`MAQC_NCHAN - 1);
	assign push      = state_reg == MAQC_CONV && adc_done;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= MAQC_IDLE;
			gap_cnt_reg <= 16'h0000;
			adc_chan    <= 4'h0;
			adc_start   <= 1'b0;
		end else begin
			adc_start <= 1'b0;
			unique case (state_reg)
				MAQC_IDLE: if (tick) begin
					adc_chan  <= 4'h0;
					adc_start <= 1'b1;
					state_reg <= MAQC_CONV;
					gap_cnt_reg <= 16'h0001;
				end
				MAQC_CONV: begin
					gap_cnt_reg <= gap_cnt_reg + 16'h0001;
					if (adc_done)
						state_reg <= last_chan ? MAQC_IDLE : MAQC_WAIT;
				end
				MAQC_WAIT: begin
					gap_cnt_reg <= gap_cnt_reg + 16'h0001;
					if (gap_cnt_reg >= gap_reg) begin
						adc_chan    <= adc_chan + 4'h1;
						adc_start   <= 1'b1;
						gap_cnt_reg <= 16'h0001;
						state_reg   <= MAQC_CONV;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// sample buffer and flags
	// ----------------------------------------------------------------
	maqc_sample_t fifo_q;
	logic [11:0]  fifo_count;
	logic         fifo_rd;
	logic         full;
	logic         eighth;
	logic         half;
	logic         ovf_reg;
	logic [3:0]   istat_reg;
	logic [3:0]   events;
	logic [3:0]   status_now;
	logic         pop_ok_reg;

	assign full    = fifo_count == 12'(`MAQC_DEPTH);
	// pop only a head that the setup cycle reported; a sample that lands in an
	// empty buffer during the read stays for the next one
	assign fifo_rd = rd_acc && sel_fifo && pop_ok_reg;
	assign eighth  = fifo_count >= 12'(`MAQC_EIGHTH_LVL);
	assign half    = fifo_count >= 12'(`MAQC_HALF_LVL);
	assign status_now = {fifo_count == 12'h000, ovf_reg, half, eighth};

	maqc_fifo maqc_fifo_inst (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (push),
		.wr_data (adc_data),
		.rd_en   (fifo_rd),
		.rd_data (fifo_q),
		.count   (fifo_count)
	);

	logic eighth_d_reg;
	logic half_d_reg;
	assign events = {1'b0, push && full, half && !half_d_reg, eighth && !eighth_d_reg};
	// clear only the bits this read reported, so an event at the setup edge survives
	logic [3:0] istat_keep;
	assign istat_keep = (rd_acc && sel_istat) ? (istat_reg & ~prdata[3:0]) : istat_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_reg      <= 1'b0;
			pop_ok_reg   <= 1'b0;
			eighth_d_reg <= 1'b0;
			half_d_reg   <= 1'b0;
			istat_reg    <= 4'h0;
		end else begin
			eighth_d_reg <= eighth;
			half_d_reg   <= half;
			pop_ok_reg   <= fifo_count != 12'h000;
			// set wins over clear
			ovf_reg <= (push && full) || (ovf_reg && !ovf_clr);
			istat_reg <= events | istat_keep;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;
	assign rd_mux =
		sel_ctrl   ? {30'h0, extclk_reg, run_reg} :
		sel_gap    ? {16'h0, gap_reg} :
		sel_status ? {28'h0, status_now} :
		sel_fifo   ? {16'h0, fifo_q} :
		sel_count  ? {20'h0, fifo_count} :
		sel_istat  ? {28'h0, istat_reg} :
		sel_imask  ? {28'h0, imask_reg} :
		sel_dir    ? {28'h0, dir_reg} :
		sel_dout   ? {28'h0, dout_reg} :
		sel_din    ? {28'h0, dio_in} :
		sel_dac    ? {20'h0, dac_value[paddr[4:2]*12 +: 12]} : 32'h0000_0000;

	// zero-wait answer: pready rises in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata       <= 32'h0000_0000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			irq          <= 1'b0;
			dio_out      <= 4'h0;
			dio_oe       <= 4'h0;
			preamp_track <= 1'b0;
			focus_enable <= 1'b0;
		end else begin
			pready       <= psel && !penable;
			pslverr      <= psel && !penable && !mapped;
			prdata       <= (psel && !penable && !pwrite) ? rd_mux : prdata;
			irq          <= |(istat_reg & imask_reg);
			dio_out      <= dout_reg;
			dio_oe       <= dir_reg;
			preamp_track <= dir_reg[`MAQC_DIO_PREAMP] && dout_reg[`MAQC_DIO_PREAMP];
			focus_enable <= dir_reg[`MAQC_DIO_FOCUS] && dout_reg[`MAQC_DIO_FOCUS];
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_one_conv: assert property (adc_start |-> state_reg == MAQC_IDLE || !$past(adc_start))
		else $error("back to back converter starts");
	chk_chan_step: assert property (adc_start && adc_chan != 4'h0 |-> adc_chan == $past(adc_chan) + 4'h1)
		else $error("channel did not advance by one");
	chk_scan_tick: assert property (int_tick |=> pace_cnt_reg == 13'h0000)
		else $error("scan period counter not reloaded");
	chk_pin_out: assert property (int_tick |=> ##1 scan_clk_out)
		else $error("scan clock pin not high after period start");
	chk_ovf_set: assert property (push && full |=> ovf_reg && istat_reg[`MAQC_ST_OVF])
		else $error("overflow not flagged");
	chk_eighth_flag: assert property (fifo_count >= 12'h100 |-> status_now[`MAQC_ST_EIGHTH])
		else $error("eighth flag missing");
	chk_half_irq: assert property ($rose(half) && imask_reg[1] |=> ##1 irq)
		else $error("half full interrupt missing");
	chk_dac_write: assert property (wr_acc && sel_dac && paddr[4:2] == 3'h0 |=> dac_value[11:0] == $past(pwdata[11:0]))
		else $error("dac 0 not updated");
	chk_focus_out: assert property (focus_enable == $past(dir_reg[1] && dout_reg[1]))
		else $error("focus enable wrong");

	// a conversion has ended, and the gap after it has not yet run out
	sequence s_conv_end;
		state_reg == MAQC_CONV && adc_done;
	endsequence
	sequence s_gap_open;
		state_reg == MAQC_WAIT && gap_cnt_reg < gap_reg;
	endsequence

	chk_gap_hold: assert property (s_gap_open |=> !adc_start)
		else $error("converter started inside the channel gap");
	chk_conv_next: assert property (s_conv_end ##0 !last_chan |=> state_reg == MAQC_WAIT)
		else $error("sequencer did not wait after a conversion");
	chk_scan_end: assert property (s_conv_end ##0 last_chan |=> state_reg == MAQC_IDLE && !adc_start)
		else $error("scan did not stop after the last channel");
	chk_ovf_drop: assert property (push && full && !fifo_rd |=> fifo_count == 12'(`MAQC_DEPTH))
		else $error("sample into a full buffer was not dropped");
	chk_eighth_irq: assert property ($rose(eighth) |=> istat_reg[`MAQC_ST_EIGHTH])
		else $error("eighth full event not latched");
	chk_apb_ready: assert property (psel && !penable |=> pready)
		else $error("no zero-wait answer to a setup cycle");
endmodule // maqc_top

/* File: verification/maqc_adc_model.sv */
// maqc_adc_model: converter on the far side of the adc port
// assumes: maqc_top drives adc_start and adc_chan on pclk
module maqc_adc_model (
	input  wire logic       pclk,
	input  wire logic       adc_start,
	input  wire logic [3:0] adc_chan,
	output logic            adc_done,
	output logic [15:0]     adc_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] ch_reg;
	int         wait_cnt = -1;
	initial begin
		adc_done = 1'b0;
		adc_data = 16'h5A5A;
	end
	// --------
	// one conversion at a time, odd channels answer slowly
	// --------
	always @(posedge pclk) begin
		adc_done <= 1'b0;
		adc_data <= ~adc_data; // data only valid with done
		if (adc_start) begin
			ch_reg <= adc_chan;
			wait_cnt <= adc_chan[0] ? 6 : 1;
		end else if (wait_cnt > 0) begin
			wait_cnt <= wait_cnt - 1;
		end else if (wait_cnt == 0) begin
			adc_done <= 1'b1;
			adc_data <= {12'hC30, ch_reg};
			wait_cnt <= -1;
		end
	end
endmodule // maqc_adc_model

/* File: verification/maqc_top_bench.sv */
// maqc_top_bench: register-level tests of the acquisition control
// assumes: apb master tasks below, converter model on the adc port
`include "maqc_defines.svh"
module maqc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        ext_scan_clk = 1'b0;
	logic        ext_on = 1'b0;
	logic [3:0]  dio_in = 4'h0;
	logic [3:0]  exp_ch = 4'h0;
	logic [31:0] prdata, rdat;
	logic        pready, pslverr, irq, scan_clk_out, adc_start, adc_done, rerr, sc_q;
	logic        preamp_track, focus_enable;
	logic [3:0]  adc_chan, dio_out, dio_oe;
	logic [15:0] adc_data;
	logic [95:0] dac_value, dexp;
	int          err_count, compares, cyc, last_st, last_rise, scan_per, scans, pi, ext_div;
	int          gap_exp = `MAQC_CHAN_GAP_CYC;

	maqc_top maqc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .scan_clk_out(scan_clk_out), .ext_scan_clk(ext_scan_clk),
		.adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data),
		.dac_value(dac_value), .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe),
		.preamp_track(preamp_track), .focus_enable(focus_enable));
	maqc_adc_model maqc_adc_model_inst (.pclk(pclk), .adc_start(adc_start),
		.adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data));

	initial begin
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		ext_div <= (ext_div == 99) ? 0 : ext_div + 1;
		if (ext_div == 99)
			ext_scan_clk <= ext_on & ~ext_scan_clk;
	end
	// --------
	// tasks
	// --------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1) begin
			chk("pready", 1, 0);
			report_and_stop;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input logic [11:0] a, input string nm, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rdat);
	endtask
	task automatic drain(input int k);
		repeat (k) begin
			rc(`MAQC_OFS_FIFO, "sample", {16'h0, 12'hC30, pi[3:0]});
			pi++;
		end
	endtask
	// host polls the fill count instead of taking the interrupt
	task automatic wait_fill(input int thr);
		int n;
		n = 0;
		do begin
			apb(1'b0, `MAQC_OFS_COUNT, 32'h0);
			n++;
		end while (rdat < thr && n < 12000);
		if (rdat < thr) begin
			chk("fill wait", thr, rdat);
			report_and_stop;
		end
	endtask
	always @(negedge pclk) begin
		cyc++;
		if (adc_start === 1'b1) begin
			chk("adc_chan", exp_ch, adc_chan);
			if (adc_chan != 0)
				chk("gap", 1, cyc - last_st >= gap_exp && cyc - last_st <= gap_exp + 12);
			scans += (adc_chan == 0);
			exp_ch++;
			last_st = cyc;
		end
		if (scan_clk_out === 1'b1 && sc_q !== 1'b1) begin
			scan_per = cyc - last_rise;
			last_rise = cyc;
		end
		sc_q = scan_clk_out;
	end
	// --------
	// tests
	// --------
	initial begin
		repeat (12) @(posedge pclk);
		chk("reset outs", 0, {irq, scan_clk_out, adc_start, dio_oe, dio_out, |dac_value});
		presetn <= 1'b1;
		rc(`MAQC_OFS_CTRL, "ctrl", 0);
		rc(`MAQC_OFS_GAP, "gap reg", `MAQC_CHAN_GAP_CYC);
		rc(`MAQC_OFS_STATUS, "status", 32'h8);
		chk("pslverr", 0, rerr);
		rc(12'h030, "unmapped", 0);
		chk("pslverr", 1, rerr);
		$display("test reset done");
		dexp = '0;
		for (int i = 0; i < 8; i++) begin
			wr(`MAQC_OFS_DAC0 + 12'(4 * i), 32'h9A0 + 32'(i));
			dexp[12 * i +: 12] = 12'h9A0 + 12'(i);
			@(negedge pclk);
			chk("dac", dexp[12 * i +: 12], dac_value[12 * i +: 12]);
		end
		chk("dac held", 1, dac_value === dexp);
		$display("test dac done");
		wr(`MAQC_OFS_DIO_DIR, 32'h3);
		wr(`MAQC_OFS_DIO_OUT, 32'hF);
		dio_in <= 4'hA;
		repeat (2) @(negedge pclk);
		chk("dio_oe", 4'h3, dio_oe);
		chk("dio_out", 2'h3, dio_out[1:0]);
		chk("modes", 2'b11, {preamp_track, focus_enable});
		wr(`MAQC_OFS_DIO_OUT, 32'h2);
		repeat (2) @(negedge pclk);
		chk("modes", 2'b01, {preamp_track, focus_enable});
		rc(`MAQC_OFS_DIO_IN, "dio_in", 32'hA);
		wr(`MAQC_OFS_DIO_DIR, 32'h0);
		repeat (2) @(negedge pclk);
		chk("modes off", 6'h0, {dio_oe, preamp_track, focus_enable});
		$display("test dio done");
		wr(`MAQC_OFS_CTRL, 32'h1);
		for (int n = 0; n < 30000 && scans < 3; n++) @(posedge pclk);
		if (scans < 3) begin
			chk("scan starts", 3, scans);
			report_and_stop;
		end
		repeat (3400) @(posedge pclk);
		wr(`MAQC_OFS_CTRL, 32'h0);
		chk("scan period", `MAQC_SCAN_CYC, scan_per);
		rc(`MAQC_OFS_COUNT, "count", 16 * scans);
		drain(16 * scans);
		$display("test onboard scan done");
		gap_exp = 4;
		wr(`MAQC_OFS_GAP, 32'h4);
		wr(`MAQC_OFS_IRQ_MASK, 32'h7);
		wr(`MAQC_OFS_CTRL, 32'h3);
		ext_on <= 1'b1;
		wait_fill(`MAQC_EIGHTH_LVL);
		rc(`MAQC_OFS_IRQ_STAT, "eighth", 32'h1);
		wait_fill(`MAQC_DEPTH);
		repeat (400) @(posedge pclk);
		ext_on <= 1'b0;
		wr(`MAQC_OFS_CTRL, 32'h0);
		rc(`MAQC_OFS_STATUS, "full", 32'h7);
		rc(`MAQC_OFS_COUNT, "count", `MAQC_DEPTH);
		@(negedge pclk);
		chk("irq", 1, irq);
		wr(`MAQC_OFS_IRQ_MASK, 32'h0);
		repeat (3) @(negedge pclk);
		chk("irq masked", 0, irq);
		wr(`MAQC_OFS_IRQ_MASK, 32'h7);
		apb(1'b0, `MAQC_OFS_IRQ_STAT, 32'h0);
		chk("half ovf irq", 2'b11, rdat[2:1]);
		drain(`MAQC_HALF_LVL + 1);
		rc(`MAQC_OFS_STATUS, "below half", 32'h5);
		drain(`MAQC_HALF_LVL - `MAQC_EIGHTH_LVL);
		rc(`MAQC_OFS_STATUS, "below eighth", 32'h4);
		wr(`MAQC_OFS_CTRL, 32'h4);
		rc(`MAQC_OFS_STATUS, "ovf cleared", 32'h0);
		drain(`MAQC_EIGHTH_LVL - 1);
		rc(`MAQC_OFS_STATUS, "empty", 32'h8);
		$display("test ext scan and flags done");
		report_and_stop;
	end
endmodule // maqc_top_bench
